// >>> rtl/mmpt_consts.svh
/*
 Constants of the maintenance monitor and pulse timer: register offsets,
 reset values, value limits and time figures. Assumes a 50 MHz clock.
*/
`ifndef MMPT_CONSTS_SVH
`define MMPT_CONSTS_SVH
`define MMPT_CLK_HZ 50000000
`define MMPT_TICK_MS 100
`define MMPT_TICK_CYC (`MMPT_CLK_HZ / 1000 * `MMPT_TICK_MS)
`define MMPT_HOUR_S 3600
`define MMPT_HOUR_TICKS (`MMPT_HOUR_S * 1000 / `MMPT_TICK_MS)
`define MMPT_HOURS_PER_UNIT 7'h64
`define MMPT_OFS_HOURS 8'h00
`define MMPT_OFS_THRESH 8'h04
`define MMPT_OFS_WINDOW 8'h08
`define MMPT_OFS_MASK 8'h0C
`define MMPT_OFS_REFCUR 8'h10
`define MMPT_OFS_SCR1 8'h14
`define MMPT_OFS_SCR2 8'h18
`define MMPT_OFS_STATUS 8'h1C
`define MMPT_OFS_MAP0 8'h20
`define MMPT_OFS_MAP1 8'h24
`define MMPT_OFS_MAP2 8'h28
`define MMPT_CNT_MAX 16'h270E
`define MMPT_OFF_VAL 16'h270F
`define MMPT_WIN_MIN 16'h0001
`define MMPT_WIN_RST 16'h000A
`define MMPT_MASK_MAX 16'h00C8
`define MMPT_REF_MAX 16'h1388
`define MMPT_FAN_HALF 8'h32
`define MMPT_T_CYCLE 8'hC8
`define MMPT_T_START 8'h0A
`define MMPT_T_INVHI 8'h23
`define MMPT_T_LOMIN 8'h05
`define MMPT_T_MAX 8'h5A
`define MMPT_T_MTMIN 8'h14
`define MMPT_PULSE_SCALE 8'h32
`define MMPT_CODE_LIFE 8'h5A
`define MMPT_CODE_PULSE 8'h5D
`define MMPT_CODE_DUE 8'h5F
`define MMPT_CODE_NEG 8'h64
`define MMPT_RELAY_IDX 2
`endif

// >>> rtl/mmpt_pkg.sv
/*
 Types of the maintenance monitor and pulse timer.
 Assumes the constants header is compiled alongside.
*/
package mmpt_pkg;
   typedef enum logic [3:0] {
      MMPT_IDLE = 4'b0000,
      MMPT_MASK = 4'b0001,
      MMPT_START = 4'b0010,
      MMPT_LOCUR = 4'b0011,
      MMPT_HIMT = 4'b0100,
      MMPT_ENDS = 4'b0101,
      MMPT_INVHI = 4'b0110,
      MMPT_INVLO = 4'b0111,
      MMPT_NODATA = 4'b1000
   } mmpt_state_e;
endpackage

// >>> rtl/mmpt_top.sv
/*
 Maintenance monitor and pulse timer: fan warning, energized hours counter
 with service alarm, current average pulse train, user scratch words and
 three output terminals, all behind an APB slave.
 Assumes the drive status inputs come from logic on sys_clk.
*/
// Summary of operation
// - Fan at or below half speed sets warning, status bit 2 and wearout alarm.
// - Powered time accumulates, hourly save strobe, counter shows 100 h units.
// - Hours counter saturates at 9998 and never wraps.
// - Counter read only; writing zero clears it only when it is 1 to 9998.
// - Service alarm when counter reaches threshold; threshold 9999 disables it.
// - Only whole hours are added; leftover fraction is dropped.
// - Monitor pulse repeats with a 20 s cycle during constant speed.
// - After reaching constant speed, samples are masked for 0 to 20 s.
// - Current averaged over 0.1 to 1.0 s during the 1 s start pulse.
// - Low pulse is average over reference times 5 s, clamped 0.5 to 9 s.
// - Reference current programmable 0 to 500 A, default rated current.
// - No masking or sampling while accelerating or decelerating.
// - Speed change in start pulse: invalid, 3.5 s high then 16.5 s low.
// - A started cycle completes even if speed keeps changing; only position control aborts it.
// - Zero current at cycle end suppresses pulses until next constant speed.
// - Cycle completed during speed change is followed by 20 s low.
// - Monitor pulse is inactive under position control.
// - Pulse maps only to the two open collector terminals, codes 93 or 193.
// - Service alarm maps to any terminal with codes 95 or 195.
// - Two scratch words take 0 to 9999, reset to 9999.
// - Scratch words steer nothing.
`timescale 1ns/1ns
`include "mmpt_consts.svh"
module mmpt_top #(
   parameter int TICK_CYC = `MMPT_TICK_CYC,
   parameter int HOUR_TICKS = `MMPT_HOUR_TICKS,
   parameter logic [15:0] RATED_CUR = 16'h0032
) (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic arst_n,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Drive status; current in 0.1 A units.
   input wire logic [7:0] fanSpeedPct,
   input wire logic [3:0] otherLifeBits,
   input wire logic constSpeed,
   input wire logic posControl,
   input wire logic [15:0] outCurrent,
   // Outputs.
   output logic wearout_alarm_out,
   output logic service_due_out,
   output logic current_avg_pulse_out,
   output logic fan_warning_display,
   output logic service_due_display,
   output logic nvSaveStrobe,
   output logic [15:0] nvHours,
   output logic [2:0] termOut
);
   mmpt_pkg::mmpt_state_e state_reg, state_next;
   logic [31:0] tickCnt_reg;
   logic [31:0] hourTick_reg;
   logic [6:0] hourSub_reg;
   logic [15:0] hours_reg, thresh_reg, window_reg, mask_reg, refCur_reg;
   logic [15:0] scr1_reg, scr2_reg;
   logic [7:0] map_reg [3];
   logic [7:0] cyc_reg, phase_reg;
   logic [31:0] sum_reg, acc_reg;
   logic [3:0] nsamp_reg;
   logic suppress_reg, pulse_reg;

   // Bus decode.
   wire logic wrEn = psel & penable & pwrite;
   wire logic hitHours = paddr == `MMPT_OFS_HOURS;
   wire logic hitThresh = paddr == `MMPT_OFS_THRESH;
   wire logic hitWindow = paddr == `MMPT_OFS_WINDOW;
   wire logic hitMask = paddr == `MMPT_OFS_MASK;
   wire logic hitRef = paddr == `MMPT_OFS_REFCUR;
   wire logic hitScr1 = paddr == `MMPT_OFS_SCR1;
   wire logic hitScr2 = paddr == `MMPT_OFS_SCR2;
   wire logic hitStat = paddr == `MMPT_OFS_STATUS;
   wire logic [2:0] hitMap = {paddr == `MMPT_OFS_MAP2,
      paddr == `MMPT_OFS_MAP1, paddr == `MMPT_OFS_MAP0};
   wire logic hitAny = hitHours | hitThresh | hitWindow | hitMask | hitRef |
      hitScr1 | hitScr2 | hitStat | (|hitMap);
   wire logic [15:0] wd = pwdata[15:0];
   wire logic wdHi0 = pwdata[31:16] == 16'h0000;
   wire logic clrHours = wrEn & hitHours & wdHi0 & wd == 16'h0000 &
      hours_reg != 16'h0000;

   // Time base and hour counting.
   wire logic tick = tickCnt_reg == 32'(TICK_CYC - 1);
   wire logic hourDone = tick & hourTick_reg == 32'(HOUR_TICKS - 1);
   wire logic unitDone = hourDone & hourSub_reg == `MMPT_HOURS_PER_UNIT - 7'h01;

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         tickCnt_reg <= 32'h00000000;
      end else begin
         tickCnt_reg <= tick ? 32'h00000000 : tickCnt_reg + 32'h00000001;
      end
   end

   // Partial hours live only here and are never saved, so a power loss
   // drops them.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         hourTick_reg <= 32'h00000000;
         hourSub_reg <= 7'h00;
         hours_reg <= 16'h0000;
         nvSaveStrobe <= 1'b0;
      end else begin
         nvSaveStrobe <= hourDone;
         if (clrHours) begin
            hourTick_reg <= 32'h00000000;
            hourSub_reg <= 7'h00;
            hours_reg <= 16'h0000;
         end else if (tick) begin
            hourTick_reg <= hourDone ? 32'h00000000 : hourTick_reg + 32'h1;
            if (hourDone) begin
               hourSub_reg <= unitDone ? 7'h00 : hourSub_reg + 7'h01;
            end
            if (unitDone && hours_reg != `MMPT_CNT_MAX) begin
               hours_reg <= hours_reg + 16'h0001;
            end
         end
      end
   end
   assign nvHours = hours_reg;

   // Configuration writes; out of range values are ignored.
   wire logic okThresh = wd <= `MMPT_OFF_VAL;
   wire logic okWindow = wd >= `MMPT_WIN_MIN & wd <= `MMPT_WIN_RST;
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         thresh_reg <= `MMPT_OFF_VAL;
         window_reg <= `MMPT_WIN_RST;
         mask_reg <= 16'h0000;
         refCur_reg <= RATED_CUR;
         scr1_reg <= `MMPT_OFF_VAL;
         scr2_reg <= `MMPT_OFF_VAL;
      end else if (wrEn && wdHi0) begin
         if (hitThresh && okThresh) thresh_reg <= wd;
         if (hitWindow && okWindow) window_reg <= wd;
         if (hitMask && wd <= `MMPT_MASK_MAX) mask_reg <= wd;
         if (hitRef && wd <= `MMPT_REF_MAX) refCur_reg <= wd;
         if (hitScr1 && okThresh) scr1_reg <= wd;
         if (hitScr2 && okThresh) scr2_reg <= wd;
      end
   end

   // Life and service alarms.
   assign fan_warning_display = fanSpeedPct <= `MMPT_FAN_HALF;
   wire logic [3:0] lifeBits = otherLifeBits |
      {1'b0, fan_warning_display, 2'b00};
   assign wearout_alarm_out = |lifeBits;
   assign service_due_out = thresh_reg != `MMPT_OFF_VAL &
      hours_reg >= thresh_reg;
   assign service_due_display = service_due_out;

   // Pulse train on 0.1 s ticks.
   wire logic run = constSpeed & ~posControl;
   wire logic [7:0] mtWidth = hours_reg[15:3] > 13'(`MMPT_T_MAX) ?
      `MMPT_T_MAX : (hours_reg[15:3] < 13'(`MMPT_T_MTMIN) ?
      `MMPT_T_MTMIN : hours_reg[10:3]);
   wire logic [35:0] refScaled = 36'(acc_reg + {16'h0000, refCur_reg}) *
      36'(window_reg[3:0]);
   wire logic [35:0] sumScaled = 36'(sum_reg) * 36'(`MMPT_PULSE_SCALE);
   wire logic loDone = (phase_reg >= `MMPT_T_LOMIN - 8'h01 &
      refScaled >= sumScaled) | phase_reg == `MMPT_T_MAX - 8'h01;
   wire logic cycEnd = cyc_reg == `MMPT_T_CYCLE - 8'h01;
   wire logic sampling = state_reg == mmpt_pkg::MMPT_START &
      {4'h0, nsamp_reg} < window_reg[7:0];

   always_comb begin
      state_next = state_reg;
      if (posControl) begin
         state_next = mmpt_pkg::MMPT_IDLE;
      end else if (tick) begin
         case (state_reg)
            mmpt_pkg::MMPT_IDLE: begin
               if (run && !suppress_reg) state_next = mmpt_pkg::MMPT_MASK;
            end
            mmpt_pkg::MMPT_MASK: begin
               if (!constSpeed) state_next = mmpt_pkg::MMPT_IDLE;
               else if ({8'h00, phase_reg} >= mask_reg)
                  state_next = mmpt_pkg::MMPT_START;
            end
            mmpt_pkg::MMPT_START: begin
               if (!constSpeed) state_next = mmpt_pkg::MMPT_INVHI;
               else if (phase_reg == `MMPT_T_START - 8'h01)
                  state_next = mmpt_pkg::MMPT_LOCUR;
            end
            mmpt_pkg::MMPT_LOCUR: begin
               if (loDone) state_next = mmpt_pkg::MMPT_HIMT;
            end
            mmpt_pkg::MMPT_HIMT: begin
               if (phase_reg == mtWidth - 8'h01)
                  state_next = mmpt_pkg::MMPT_ENDS;
            end
            mmpt_pkg::MMPT_INVHI: begin
               if (cyc_reg == `MMPT_T_INVHI - 8'h01)
                  state_next = mmpt_pkg::MMPT_INVLO;
            end
            mmpt_pkg::MMPT_ENDS, mmpt_pkg::MMPT_INVLO: begin
               if (cycEnd) begin
                  if (outCurrent == 16'h0000)
                     state_next = mmpt_pkg::MMPT_IDLE;
                  else if (!constSpeed)
                     state_next = mmpt_pkg::MMPT_NODATA;
                  else
                     state_next = mmpt_pkg::MMPT_START;
               end
            end
            mmpt_pkg::MMPT_NODATA: begin
               if (cycEnd) state_next = mmpt_pkg::MMPT_IDLE;
            end
            default: state_next = mmpt_pkg::MMPT_IDLE;
         endcase
      end
   end

   wire logic stepSt = state_next != state_reg;
   wire logic newCyc = stepSt & (state_next == mmpt_pkg::MMPT_START |
      state_next == mmpt_pkg::MMPT_NODATA);
   wire logic inCyc = state_reg != mmpt_pkg::MMPT_IDLE &
      state_reg != mmpt_pkg::MMPT_MASK;

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= mmpt_pkg::MMPT_IDLE;
         cyc_reg <= 8'h00;
         phase_reg <= 8'h00;
      end else begin
         state_reg <= state_next;
         if (newCyc || !inCyc && stepSt) cyc_reg <= 8'h00;
         else if (tick && inCyc) cyc_reg <= cyc_reg + 8'h01;
         if (stepSt) phase_reg <= 8'h00;
         else if (tick && phase_reg != 8'hFF) phase_reg <= phase_reg + 8'h01;
      end
   end

   // Sum of samples, then the reference accumulated once per low tick;
   // the low pulse ends when ref * ticks * window reaches sum * 50,
   // which avoids a divider.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         sum_reg <= 32'h00000000;
         acc_reg <= 32'h00000000;
         nsamp_reg <= 4'h0;
      end else if (stepSt && state_next == mmpt_pkg::MMPT_START) begin
         sum_reg <= 32'h00000000;
         acc_reg <= 32'h00000000;
         nsamp_reg <= 4'h0;
      end else if (tick && sampling && constSpeed) begin
         sum_reg <= sum_reg + {16'h0000, outCurrent};
         nsamp_reg <= nsamp_reg + 4'h1;
      end else if (tick && state_reg == mmpt_pkg::MMPT_LOCUR) begin
         acc_reg <= acc_reg + {16'h0000, refCur_reg};
      end
   end

   // Suppression lasts until constant speed is lost.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         suppress_reg <= 1'b0;
      end else if (!constSpeed) begin
         suppress_reg <= 1'b0;
      end else if (stepSt && state_next == mmpt_pkg::MMPT_IDLE &&
         inCyc && outCurrent == 16'h0000) begin
         suppress_reg <= 1'b1;
      end
   end

   wire logic pulseHigh = state_reg == mmpt_pkg::MMPT_START |
      state_reg == mmpt_pkg::MMPT_HIMT | state_reg == mmpt_pkg::MMPT_INVHI;
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) pulse_reg <= 1'b0;
      else pulse_reg <= pulseHigh;
   end
   assign current_avg_pulse_out = pulse_reg;

   // Terminal mapping; the relay terminal refuses the pulse codes.
   wire logic [7:0] wdCode = wd[7:0];
   wire logic [7:0] wdBase = wdCode >= `MMPT_CODE_NEG + `MMPT_CODE_LIFE ?
      wdCode - `MMPT_CODE_NEG : wdCode;
   wire logic codeOk = wd[15:8] == 8'h00 & (wdBase == `MMPT_CODE_LIFE |
      wdBase == `MMPT_CODE_PULSE | wdBase == `MMPT_CODE_DUE);
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_term
         wire logic [7:0] base = map_reg[gi] >= `MMPT_CODE_NEG ?
            map_reg[gi] - `MMPT_CODE_NEG : map_reg[gi];
         wire logic neg = map_reg[gi] >= `MMPT_CODE_NEG;
         wire logic src = base == `MMPT_CODE_LIFE ? wearout_alarm_out :
            base == `MMPT_CODE_PULSE ? pulse_reg :
            base == `MMPT_CODE_DUE & service_due_out;
         wire logic refuse = gi == `MMPT_RELAY_IDX &
            wdBase == `MMPT_CODE_PULSE;
         always_ff @(posedge sys_clk or negedge arst_n) begin
            if (!arst_n) begin
               map_reg[gi] <= `MMPT_CODE_LIFE;
               termOut[gi] <= 1'b0;
            end else begin
               if (wrEn && hitMap[gi] && wdHi0 && codeOk && !refuse)
                  map_reg[gi] <= wdCode;
               termOut[gi] <= src ^ neg;
            end
         end
      end
   endgenerate

   // Read mux; reads have no side effects. Scratch words only read back.
   wire logic [15:0] statWord = {6'h00, state_reg, service_due_display,
      fan_warning_display, lifeBits};
   wire logic [15:0] rdWord = hitHours ? hours_reg :
      hitThresh ? thresh_reg : hitWindow ? window_reg :
      hitMask ? mask_reg : hitRef ? refCur_reg :
      hitScr1 ? scr1_reg : hitScr2 ? scr2_reg :
      hitStat ? statWord : hitMap[0] ? {8'h00, map_reg[0]} :
      hitMap[1] ? {8'h00, map_reg[1]} : {8'h00, map_reg[2]};
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~hitAny;
   assign prdata = hitAny ? {16'h0000, rdWord} : 32'h00000000;

   // Checks.
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   sequence s_clear;
      wrEn && hitHours && pwdata == 32'h0 && hours_reg != 16'h0;
   endsequence
   chk_hours_clear: assert property (s_clear |=> hours_reg == 16'h0)
      else $error("hours not cleared");
   chk_zero_locked: assert property (wrEn && hitHours && hours_reg == 16'h0
      && !unitDone |=> hours_reg == 16'h0)
      else $error("hours changed by write at zero");
   chk_hours_sat: assert property (hours_reg <= `MMPT_CNT_MAX)
      else $error("hours above limit");
   chk_hours_step: assert property (!$past(unitDone) && !$past(clrHours)
      |-> $stable(hours_reg))
      else $error("hours moved without a whole unit");
   chk_due_off: assert property (thresh_reg == `MMPT_OFF_VAL
      |-> !service_due_out)
      else $error("alarm while disabled");
   chk_fan_bit: assert property (fanSpeedPct <= `MMPT_FAN_HALF
      |-> statWord[2] && wearout_alarm_out)
      else $error("fan warning missing");
   chk_pos_idle: assert property (posControl |=> state_reg ==
      mmpt_pkg::MMPT_IDLE ##1 !current_avg_pulse_out)
      else $error("pulse under position control");
   chk_cycle_len: assert property (inCyc |-> cyc_reg < `MMPT_T_CYCLE)
      else $error("cycle beyond 20 s");
   chk_invalid_hi: assert property (state_reg == mmpt_pkg::MMPT_INVLO
      |-> cyc_reg >= `MMPT_T_INVHI)
      else $error("invalid high too short");
   chk_low_width: assert property (state_reg == mmpt_pkg::MMPT_LOCUR
      |-> phase_reg < `MMPT_T_MAX)
      else $error("current pulse too long");
   chk_relay_map: assert property (map_reg[2] != `MMPT_CODE_PULSE &&
      map_reg[2] != `MMPT_CODE_PULSE + `MMPT_CODE_NEG)
      else $error("pulse mapped to relay");
endmodule

// >>> test/maintenance_monitor_pulse_timer_test.sv
/*
 Self-checking bench of the maintenance monitor and pulse timer.
 Assumes a 4-cycle tick and a 3-tick hour so that all figures are short.
*/
`timescale 1ns/1ns
`include "mmpt_consts.svh"
module maintenance_monitor_pulse_timer_test;
   localparam int TC = 4;
   logic sys_clk, arst_n, psel, penable, pwrite, constSpeed, posControl;
   logic [7:0] paddr, fanSpeedPct;
   logic [31:0] pwdata, prdata, r;
   logic pready, pslverr, e, wearOut, dueOut, pulseOut, fanDisp, dueDisp;
   logic nvSaveStrobe;
   logic [3:0] otherLifeBits;
   logic [15:0] outCurrent, nvHours, lastWidth, edgeCount, ecnt;
   logic [2:0] termOut;
   int mismatches, n_tests, cycles, strobes;
   logic [15:0] curTab [3] = '{16'h0032, 16'h00C8, 16'h0001};
   int loTab [3] = '{200, 360, 20};
   logic [15:0] thrTab [4] = '{16'h0001, 16'h0002, 16'h0000, 16'h270F};
   logic dueTab [4] = '{1'b1, 1'b0, 1'b1, 1'b0};

   mmpt_top #(.TICK_CYC(TC), .HOUR_TICKS(3)) mmpt_top_inst (
      .sys_clk(sys_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .fanSpeedPct(fanSpeedPct),
      .otherLifeBits(otherLifeBits), .constSpeed(constSpeed),
      .posControl(posControl), .outCurrent(outCurrent),
      .wearout_alarm_out(wearOut), .service_due_out(dueOut),
      .current_avg_pulse_out(pulseOut), .fan_warning_display(fanDisp),
      .service_due_display(dueDisp), .nvSaveStrobe(nvSaveStrobe),
      .nvHours(nvHours), .termOut(termOut));

   mmpt_plc_input mmpt_plc_input_inst (
      .sys_clk(sys_clk), .arst_n(arst_n), .pulseIn(pulseOut),
      .lastWidth(lastWidth), .edgeCount(edgeCount));

   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   always @(posedge sys_clk) begin
      cycles++;
      if (nvSaveStrobe === 1'b1) strobes++;
      if (cycles > 20000) begin
         mismatches++;
         report_and_stop();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) mismatches++;
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      check(r, exp);
   endtask

   // Waits for the next level change on the pulse line, bounded.
   task automatic wedge(input int exp);
      logic [15:0] e0;
      int n;
      e0 = edgeCount;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (edgeCount === e0 && n < 1000);
      if (exp >= 0 && n >= 1000) mismatches++;
      if (exp >= 0) check(lastWidth, exp);
   endtask

   task automatic report_and_stop();
      $display("mismatches %0d n_tests %0d", mismatches, n_tests);
      if (mismatches == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   initial begin
      arst_n = 1'b0;
      {psel, penable, pwrite, constSpeed, posControl} = 5'b00000;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      fanSpeedPct = 8'h64;
      otherLifeBits = 4'h0;
      outCurrent = curTab[0];
      repeat (6) @(posedge sys_clk);
      arst_n <= 1'b1;
      rd_chk(`MMPT_OFS_HOURS, 32'h0000_0000);
      rd_chk(`MMPT_OFS_THRESH, 32'h0000_270F);
      rd_chk(`MMPT_OFS_WINDOW, 32'h0000_000A);
      rd_chk(`MMPT_OFS_MASK, 32'h0000_0000);
      rd_chk(`MMPT_OFS_REFCUR, 32'h0000_0032);
      rd_chk(`MMPT_OFS_SCR1, 32'h0000_270F);
      rd_chk(`MMPT_OFS_SCR2, 32'h0000_270F);
      apb(1'b1, `MMPT_OFS_SCR1, 32'h0000_04D2);
      apb(1'b1, `MMPT_OFS_SCR2, 32'h0000_2710);
      rd_chk(`MMPT_OFS_SCR1, 32'h0000_04D2);
      rd_chk(`MMPT_OFS_SCR2, 32'h0000_270F);
      check(dueOut, 1'b0);
      apb(1'b0, 8'h40, 32'h0000_0000);
      check(e, 1'b1);
      check(r, 32'h0000_0000);
      apb(1'b1, `MMPT_OFS_HOURS, 32'h0000_0005);
      rd_chk(`MMPT_OFS_HOURS, 32'h0000_0000);
      fanSpeedPct <= 8'h32;
      apb(1'b0, `MMPT_OFS_STATUS, 32'h0000_0000);
      check({r[2], fanDisp, wearOut}, 3'b111);
      fanSpeedPct <= 8'h33;
      @(posedge sys_clk);
      @(posedge sys_clk);
      check({fanDisp, wearOut}, 2'b00);
      apb(1'b1, `MMPT_OFS_MAP0, 32'h0000_005D);
      apb(1'b1, `MMPT_OFS_MAP2, 32'h0000_005D);
      rd_chk(`MMPT_OFS_MAP0, 32'h0000_005D);
      rd_chk(`MMPT_OFS_MAP2, 32'h0000_005A);
      apb(1'b1, `MMPT_OFS_MAP2, 32'h0000_00C3);
      rd_chk(`MMPT_OFS_MAP2, 32'h0000_00C3);
      // One hundred hour strobes make one counter unit.
      for (int n = 0; n < 1600 && nvHours !== 16'h0001; n++)
         @(posedge sys_clk);
      @(posedge sys_clk);
      @(posedge sys_clk);
      check(strobes, 100);
      rd_chk(`MMPT_OFS_HOURS, 32'h0000_0001);
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, `MMPT_OFS_THRESH, {16'h0000, thrTab[i]});
         // The terminal output is registered, so it lags one more clock.
         repeat (2) @(posedge sys_clk);
         check({dueOut, dueDisp, termOut[2]}, {3{dueTab[i]}} ^ 3'b001);
      end
      apb(1'b1, `MMPT_OFS_HOURS, 32'h0000_0005);
      rd_chk(`MMPT_OFS_HOURS, 32'h0000_0001);
      apb(1'b1, `MMPT_OFS_HOURS, 32'h0000_0000);
      rd_chk(`MMPT_OFS_HOURS, 32'h0000_0000);
      // Full cycles: start 10 ticks, low from current, hours 20 ticks.
      constSpeed <= 1'b1;
      wedge(-1);
      for (int i = 0; i < 3; i++) begin
         wedge(10 * TC);
         wedge(loTab[i]);
         wedge(20 * TC);
         if (i < 2) outCurrent <= curTab[i + 1];
         wedge(200 * TC - 30 * TC - loTab[i]);
      end
      // Speed lost during the start pulse marks the data invalid.
      repeat (8) @(posedge sys_clk);
      constSpeed <= 1'b0;
      wedge(35 * TC);
      ecnt = edgeCount;
      repeat (1000) @(posedge sys_clk);
      apb(1'b0, `MMPT_OFS_STATUS, 32'h0000_0000);
      check(r[9:6], mmpt_pkg::MMPT_NODATA);
      check(edgeCount, ecnt);
      check(pulseOut, 1'b0);
      repeat (700) @(posedge sys_clk);
      posControl <= 1'b1;
      constSpeed <= 1'b1;
      repeat (600) @(posedge sys_clk);
      check(pulseOut, 1'b0);
      // Zero current: one minimum cycle, then no pulses while speed holds.
      posControl <= 1'b0;
      outCurrent <= 16'h0000;
      wedge(-1);
      wedge(10 * TC);
      wedge(5 * TC);
      wedge(20 * TC);
      ecnt = edgeCount;
      repeat (1200) @(posedge sys_clk);
      check(edgeCount, ecnt);
      check(pulseOut, 1'b0);
      report_and_stop();
   end

   initial begin
      mismatches = 0;
      n_tests = 0;
      cycles = 0;
      strobes = 0;
   end
endmodule

// >>> test/mmpt_plc_input.sv
/*
 Model of the programmable controller input that reads the current
 average pulse train: it measures how long each level stood, in clocks.
 Assumes the pulse line is a registered output on the same clock.
*/
`timescale 1ns/1ns
module mmpt_plc_input (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic arst_n,
   // Monitored line.
   input wire logic pulseIn,
   // Measurements.
   output logic [15:0] lastWidth,
   output logic [15:0] edgeCount
);
   logic level_reg;
   logic [15:0] run_reg;

   // The input only samples; it never drives anything back into the drive.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         level_reg <= 1'b0;
         run_reg <= 16'h0000;
         lastWidth <= 16'h0000;
         edgeCount <= 16'h0000;
      end else if (pulseIn !== level_reg) begin
         level_reg <= pulseIn;
         lastWidth <= run_reg;
         run_reg <= 16'h0001;
         edgeCount <= edgeCount + 16'h0001;
      end else begin
         run_reg <= run_reg + 16'h0001;
      end
   end
endmodule
